// >>> rtl/sar_adc_ctrl.sv
`default_nettype none

// ==========================================================================
// Control of a serial successive-approximation converter
// ==========================================================================
// The select, serial bit clock and comparator pins are all foreign to the
// system clock. They are sampled and filtered here; a filtered select fall
// starts a frame, and every step within it is taken on a filtered falling
// edge of the serial bit clock.
// A frame, counted in filtered falls of the bit clock while select is low:
//    fall 1       sampling only, the pin stays floated
//    fall 2       the pin drives the low null bit, top trial is applied
//    falls 3-14   one decision each, driven out at once, top bit first
//    fall 14      word complete: analog section off, word buffered
//    falls 15-25  the word again from bit 1, bottom up, to the top bit
//    fall 26      the pin floats; later falls are ignored
// Every output moves one system clock after the filtered event, some four
// system clocks after the pin itself moved. The bit clock must therefore
// stay at each level for at least three system clocks; faster pin activity
// is not seen reliably by the filter.
// Select high at any time wins over everything else: it floats the pin,
// powers both sections down and returns the sequencer to idle.

module sar_adc_ctrl #(
   parameter int unsigned RES_BITS = sar_pkg::RESULT_BITS,
   parameter int unsigned DEPTH = sar_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic selectN,
   input wire logic serialBitClock,
   input wire logic compare,
   output logic serialDataOut,
   output logic serialDataOeN,
   output logic analogPowerOn,
   output logic digitalActive,
   output logic [RES_BITS-1:0] trialCode,
   output logic resultValid,
   output logic [RES_BITS-1:0] resultData,
   input wire logic resultReady
);

   // Index width and the end points of the bit index
   localparam int unsigned IW = $clog2(RES_BITS + 1);
   localparam logic [IW-1:0] TOP_IDX = IW'(RES_BITS - 1);
   localparam logic [IW-1:0] END_IDX = IW'(RES_BITS);
   localparam logic [RES_BITS-1:0] TOP_TRIAL =
      RES_BITS'(sar_pkg::FIRST_TRIAL) << (RES_BITS - sar_pkg::RESULT_BITS);

   // ========================================================================
   // Pin synchronisers
   // ========================================================================
   sar_pkg::sar_pins_s pinMeta_q;
   sar_pkg::sar_pins_s pinSync_q;
   sar_pkg::sar_pins_s pinCheck_q;
   sar_pkg::sar_pins_s pinFilt_q;
   sar_pkg::sar_pins_s pinFilt_d;
   sar_pkg::sar_pins_s pinRaw;

   assign pinRaw = '{
      selectN: selectN,
      serialBitClock: serialBitClock,
      compare: compare
   };

   // A bit moves only when the second and third stages agree, else holds
   assign pinFilt_d = (pinSync_q & pinCheck_q)
      | (pinFilt_q & (pinSync_q | pinCheck_q));

   // Reset values equal the idle pin levels, so no false edge follows reset.
   // Limitation: a pulse shorter than three system clocks may be lost.
   // Three-stage chain; the first stage feeds nothing but the second
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pinMeta_q <= sar_pkg::PINS_RST;
         pinSync_q <= sar_pkg::PINS_RST;
         pinCheck_q <= sar_pkg::PINS_RST;
         pinFilt_q <= sar_pkg::PINS_RST;
      end else if (ce) begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
         pinCheck_q <= pinSync_q;
         pinFilt_q <= pinFilt_d;
      end
   end

   // ========================================================================
   // Edge events on the filtered pins
   // ========================================================================
   logic selRise;
   logic selFall;
   logic bitFall;
   logic cmpBit;

   // Next filtered value against the held one: each acts as the filter moves
   assign selRise = pinFilt_d.selectN & ~pinFilt_q.selectN;
   assign selFall = ~pinFilt_d.selectN & pinFilt_q.selectN;
   assign bitFall = ~pinFilt_d.serialBitClock & pinFilt_q.serialBitClock;
   assign cmpBit = pinFilt_d.compare;

   // ========================================================================
   // Sequencer state
   // ========================================================================
   // The index points at the bit under decision while converting, and at
   // the next bit to repeat afterwards. The trial code is offset binary for
   // the weighing array; the result is kept two's complement for the pin.
   sar_pkg::sar_state_e state_q;
   sar_pkg::sar_state_e state_d;
   logic [IW-1:0] idx_q;
   logic [IW-1:0] idx_d;
   logic [RES_BITS-1:0] trial_q;
   logic [RES_BITS-1:0] trial_d;
   logic [RES_BITS-1:0] res_q;
   logic [RES_BITS-1:0] res_d;
   logic dout_q;
   logic dout_d;
   logic doutOeN_q;
   logic doutOeN_d;
   logic analog_q;
   logic analog_d;
   logic digital_q;
   logic digital_d;
   logic sampled_q;
   logic sampled_d;
   logic push;
   logic fifoReady;
   logic outBit;
   logic isTopBit;

   // Comparator high keeps the trial bit; the top bit is inverted
   // because the array weighs offset binary but the word is signed
   assign isTopBit = (idx_q == TOP_IDX);
   assign outBit = isTopBit ? ~cmpBit : cmpBit;

   // Digital side follows select alone, even after the word is done
   assign digital_d = ~pinFilt_d.selectN;

   // Next state of the sequencer
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      trial_d = trial_q;
      res_d = res_q;
      dout_d = dout_q;
      doutOeN_d = doutOeN_q;
      analog_d = analog_q;
      sampled_d = sampled_q;
      push = 1'b0;
      if (selRise || pinFilt_d.selectN) begin
         // Abort: float the pin, power down, back to idle
         state_d = sar_pkg::ST_IDLE;
         doutOeN_d = 1'b1;
         sampled_d = 1'b0;
         analog_d = 1'b0;
         idx_d = '0;
      end else if (selFall) begin
         // Only a fresh fall starts; a full buffer skips this frame
         if (fifoReady) begin
            state_d = sar_pkg::ST_SAMPLE;
            analog_d = 1'b1;
            sampled_d = 1'b0;
            trial_d = '0;
            res_d = '0;
         end
      end else if (bitFall) begin
         unique case (state_q)
            sar_pkg::ST_IDLE: begin
               // Falls of a refused frame are ignored
               state_d = state_q;
            end
            sar_pkg::ST_SAMPLE: begin
               if (sampled_q) begin
                  // Second falling edge: low null bit, first trial set
                  state_d = sar_pkg::ST_NULL;
                  dout_d = 1'b0;
                  doutOeN_d = 1'b0;
                  trial_d = TOP_TRIAL;
                  idx_d = TOP_IDX;
               end else begin
                  sampled_d = 1'b1;
               end
            end
            sar_pkg::ST_NULL,
            sar_pkg::ST_CONV: begin
               // One decision per falling edge, driven out at once
               state_d = sar_pkg::ST_CONV;
               dout_d = outBit;
               res_d[idx_q] = outBit;
               trial_d[idx_q] = cmpBit;
               if (idx_q != '0) begin
                  trial_d[idx_q - 1'b1] = 1'b1;
                  idx_d = idx_q - 1'b1;
               end else begin
                  // Bottom bit decided: word complete, analog off
                  state_d = sar_pkg::ST_REPEAT;
                  analog_d = 1'b0;
                  push = 1'b1;
                  idx_d = IW'(1);
               end
            end
            sar_pkg::ST_REPEAT: begin
               if (idx_q == END_IDX) begin
                  // Top bit repeated already: float and go deaf
                  state_d = sar_pkg::ST_DONE;
                  doutOeN_d = 1'b1;
               end else begin
                  dout_d = res_q[idx_q];
                  idx_d = idx_q + 1'b1;
               end
            end
            sar_pkg::ST_DONE: begin
               // Deaf until select goes high again
               state_d = state_q;
            end
            default: begin
               state_d = sar_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= sar_pkg::ST_IDLE;
         idx_q <= '0;
         trial_q <= '0;
         res_q <= '0;
         sampled_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         idx_q <= idx_d;
         trial_q <= trial_d;
         res_q <= res_d;
         sampled_q <= sampled_d;
      end
   end

   // Pin and power outputs, each from its own flop
   // The power flags are reports for the supply switches outside the block
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dout_q <= sar_pkg::DOUT_RST;
         doutOeN_q <= sar_pkg::DOUT_OE_N_RST;
         analog_q <= 1'b0;
         digital_q <= 1'b0;
      end else if (ce) begin
         dout_q <= dout_d;
         doutOeN_q <= doutOeN_d;
         analog_q <= analog_d;
         digital_q <= digital_d;
      end
   end

   // Ports straight from the flops above
   assign serialDataOut = dout_q;
   assign serialDataOeN = doutOeN_q;
   assign analogPowerOn = analog_q;
   assign digitalActive = digital_q;
   assign trialCode = trial_q;

   // ========================================================================
   // Result word buffer
   // ========================================================================
   // Whole words go to the user side only; the pin never waits on this.
   // The price is that a frame starting with the buffer full is skipped.
   // A word is pushed from the next-state value as its bottom bit is decided;
   // the ready flag is the only path from the buffer back into the sequencer.
   sar_fifo #(
      .WIDTH(RES_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .ce(ce),
      .inValid(push),
      .inData(res_d),
      .inReady(fifoReady),
      .outValid(resultValid),
      .outData(resultData),
      .outReady(resultReady)
   );

endmodule // sar_adc_ctrl

`default_nettype wire

// >>> rtl/sar_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants and types of the converter control block
// ==========================================================================
package sar_pkg;

   // Result word width and the fixed output word depth
   localparam int unsigned RESULT_BITS = 12;
   localparam int unsigned FIFO_DEPTH = 4;

   // Falling bit clock edges spent sampling before the null bit
   localparam int unsigned SAMPLE_FALLS = 1;

   // Result codes of the two's complement scale
   localparam logic [11:0] CODE_NEG_FULL = 12'h800;
   localparam logic [11:0] CODE_ZERO = 12'h000;
   localparam logic [11:0] CODE_POS_FULL = 12'h7FF;

   // Trial code for the first decision: top bit under test
   localparam logic [11:0] FIRST_TRIAL = 12'h800;

   // Reset values of the output pins
   localparam logic DOUT_RST = 1'b0;
   localparam logic DOUT_OE_N_RST = 1'b1;

   // Pins that arrive from outside the clock domain, carried together
   typedef struct packed {
      logic selectN;
      logic serialBitClock;
      logic compare;
   } sar_pins_s;

   // Idle pin levels: select high means full power down
   localparam sar_pins_s PINS_RST = '{
      selectN: 1'b1,
      serialBitClock: 1'b0,
      compare: 1'b0
   };

   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SAMPLE = 6'h02,
      ST_NULL = 6'h04,
      ST_CONV = 6'h08,
      ST_REPEAT = 6'h10,
      ST_DONE = 6'h20
   } sar_state_e;

endpackage : sar_pkg

`default_nettype wire

// >>> rtl/sar_fifo.sv
`default_nettype none

// ==========================================================================
// Shifting word buffer: the head always sits in entry zero
// ==========================================================================
module sar_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);

   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic valid_q;
   logic push;
   logic pop;

   // Head kept in a flop so the output needs no read multiplexer
   assign inReady = (count_q != CW'(DEPTH));
   assign push = inValid & inReady;
   assign pop = valid_q & outReady;
   assign count_d = count_q + CW'(push) - CW'(pop);
   assign outValid = valid_q;
   assign outData = mem[0];

   // Occupancy and the registered empty flag
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_q <= '0;
         valid_q <= 1'b0;
      end else if (ce) begin
         count_q <= count_d;
         valid_q <= (count_d != '0);
      end
   end

   // Each entry shifts down on a pop and loads when it is the tail
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      logic [WIDTH-1:0] above;
      if (i + 1 < DEPTH) begin : g_mid
         assign above = mem[i+1];
      end else begin : g_top
         assign above = mem[i];
      end
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            mem[i] <= '0;
         end else if (ce) begin
            if (pop) begin
               mem[i] <= (push && count_q == CW'(i + 1)) ? inData : above;
            end else if (push && count_q == CW'(i)) begin
               mem[i] <= inData;
            end
         end
      end
   end

endmodule // sar_fifo

`default_nettype wire

// >>> sim/sar_adc_ctrl_checker.sv
`default_nettype none

// ==========================================================================
// Port checks; the pin filter delays every reaction by about 4 clocks
// ==========================================================================
module sar_adc_ctrl_checker #(
   parameter int unsigned RES_BITS = 12,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic selectN,
   input wire logic serialBitClock,
   input wire logic compare,
   input wire logic serialDataOut,
   input wire logic serialDataOeN,
   input wire logic analogPowerOn,
   input wire logic digitalActive,
   input wire logic [RES_BITS-1:0] trialCode,
   input wire logic resultValid,
   input wire logic [RES_BITS-1:0] resultData,
   input wire logic resultReady
);
   logic clkSeen_q;
   logic [3:0] sinceFall_q;
   logic [4:0] frame_q;
   wire logic bitFell = clkSeen_q && !serialBitClock;
   wire logic [3:0] sinceInc = {3'h0, sinceFall_q != 4'hF};
   // Raw falls per frame, cleared while select is high
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         clkSeen_q <= 1'b0;
         sinceFall_q <= 4'hF;
         frame_q <= 5'h00;
      end else begin
         clkSeen_q <= serialBitClock;
         sinceFall_q <= bitFell ? 4'h0 : sinceFall_q + sinceInc;
         frame_q <= selectN ? 5'h00 : frame_q + {4'h0, bitFell};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_idle_all_off:
      assert property (selectN [*6] |-> serialDataOeN && !analogPowerOn &&
         !digitalActive) else $error("Block active with select high");
   a_digital_on:
      assert property (!selectN [*6] |-> digitalActive)
      else $error("Digital section off with select low");
   a_dout_on_fall:
      assert property ($changed(serialDataOut) |-> sinceFall_q inside {[1:6]})
      else $error("Data changed away from a bit clock fall");
   a_null_bit:
      assert property ($fell(serialDataOeN) |-> !serialDataOut &&
         trialCode == 12'h800 && frame_q == 5'h02) else $error("Bad null bit");
   a_trial_on_fall:
      assert property ($changed(trialCode) |-> sinceFall_q inside {[1:6]} ||
         selectN || frame_q == 5'h00)
      else $error("Trial code moved without a fall");
   a_analog_bound:
      assert property (analogPowerOn |-> frame_q <= 5'h0E)
      else $error("Analog on past the last decision");
   a_analog_cause:
      assert property ($fell(analogPowerOn) |-> frame_q == 5'h0E || selectN)
      else $error("Analog off too early");
   a_analog_held:
      assert property (frame_q inside {[1:13]} && !serialDataOeN |->
         analogPowerOn) else $error("Analog off mid conversion");
   a_drive_window:
      assert property (!serialDataOeN && !selectN |-> frame_q inside {[2:26]})
      else $error("Output driven outside its window");
   a_float_end:
      assert property (frame_q == 5'h1A && sinceFall_q == 4'h4 |->
         serialDataOeN) else $error("Output not floated after repeat");
   a_word_holds:
      assert property (resultValid && !resultReady |=> resultValid &&
         $stable(resultData)) else $error("Buffered word not held");
   c_abort: cover property ($rose(selectN) && !serialDataOeN);
   c_full: cover property (frame_q == 5'h1A && $rose(serialDataOeN));
   c_pop: cover property (resultValid && resultReady);
endmodule // sar_adc_ctrl_checker

bind sar_adc_ctrl sar_adc_ctrl_checker #(.RES_BITS(RES_BITS), .DEPTH(DEPTH))
   chk_u (.clock(clock), .nrst(nrst), .ce(ce), .selectN(selectN),
   .serialBitClock(serialBitClock), .compare(compare),
   .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN),
   .analogPowerOn(analogPowerOn), .digitalActive(digitalActive),
   .trialCode(trialCode), .resultValid(resultValid),
   .resultData(resultData), .resultReady(resultReady));

`default_nettype wire

// >>> sim/sar_host_model.sv
`default_nettype none

// ==========================================================================
// Host side: select and bit clock, bits read just before each rise
// ==========================================================================
module sar_host_model (
   input wire logic clock,
   input wire logic serialDataOut,
   input wire logic serialDataOeN,
   output logic selectN,
   output logic serialBitClock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [26:1] capData;
   logic [26:1] capOeN;
   // Bit clock stands low and select high between frames
   initial begin
      selectN = 1'b1;
      serialBitClock = 1'b0;
   end
   // Half periods of 16 clocks: about 3.1 MHz, and far past the filter
   localparam int HALF = 16;
   task automatic frame(input int n);
      @(negedge clock);
      selectN = 1'b0;
      repeat (HALF) @(negedge clock);
      for (int i = 1; i <= n; i++) begin
         serialBitClock = 1'b1;
         repeat (HALF) @(negedge clock);
         serialBitClock = 1'b0;
         repeat (HALF) @(negedge clock);
         // A floated line reads as the inverse of the last driven level
         capData[i] = serialDataOeN ? ~serialDataOut : serialDataOut;
         capOeN[i] = serialDataOeN;
      end
      selectN = 1'b1;
      repeat (8) @(negedge clock);
   endtask
endmodule // sar_host_model

`default_nettype wire

// >>> sim/tb.sv
`default_nettype none

// ==========================================================================
// Bench: conversions, short cycles, a refused frame and buffer drain
// ==========================================================================
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic compare = 1'b0;
   logic resultReady = 1'b0;
   logic drainOn = 1'b0;
   logic selectN, serialBitClock, serialDataOut, serialDataOeN;
   logic analogPowerOn, digitalActive, resultValid;
   logic [11:0] trialCode, resultData;
   logic [11:0] vin = 12'h000;
   logic [31:0] rng = 32'h000124B8;
   logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
   logic [11:0] expQ [$];
   int err_count = 0;
   int checked = 0;

   always #5 clock = ~clock;

   sar_adc_ctrl dut_u (.clock(clock), .nrst(nrst), .ce(1'b1),
      .selectN(selectN), .serialBitClock(serialBitClock), .compare(compare),
      .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN),
      .analogPowerOn(analogPowerOn), .digitalActive(digitalActive),
      .trialCode(trialCode), .resultValid(resultValid),
      .resultData(resultData), .resultReady(resultReady));

   sar_host_model host_u (.clock(clock), .serialDataOut(serialDataOut),
      .serialDataOeN(serialDataOeN), .selectN(selectN),
      .serialBitClock(serialBitClock));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Expected {output enable low, data} after fall i of a full frame
   function automatic logic [1:0] expPin(input logic [11:0] r, input int i);
      if (i < 2 || i > 25) return 2'h2;
      if (i == 2) return 2'h0;
      return {1'b0, i < 15 ? r[14 - i] : r[i - 14]};
   endfunction

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: mismatch got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Mode 0 short cycle, 1 full word noted, 2 refused with buffer full
   task automatic convert(input logic [11:0] v, input int n, input int mode);
      logic [11:0] r;
      logic [1:0] e;
      logic [1:0] g;
      vin = v;
      r = v ^ 12'h800;
      if (mode == 1) expQ.push_back(r);
      host_u.frame(n);
      for (int i = 1; i <= n; i++) begin
         e = (mode == 2) ? 2'h2 : expPin(r, i);
         g = {host_u.capOeN[i], host_u.capData[i]};
         if (e[1]) chk({11'h0, g[1]}, 12'h001);
         else chk({10'h0, g}, {10'h0, e});
      end
      chk({9'h0, serialDataOeN, analogPowerOn, digitalActive}, 12'h004);
   endtask

   // Comparator: offset binary input against the trial code
   always @(negedge clock) begin
      compare <= (trialCode <= vin);
      rng <= xs(rng);
      resultReady <= drainOn & rng[0];
   end

   // Each pop is matched with the oldest noted word
   always @(posedge clock) begin
      if (nrst && resultValid === 1'b1 && resultReady === 1'b1) begin
         chk(resultData, expQ.size() ? expQ.pop_front() : ~resultData);
      end
   end

   // Hang guard, well beyond the expected run of some 10000 cycles
   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      // Scale end and mid-scale codes fill the buffer, so the fifth frame is refused
      foreach (codes[k]) convert(codes[k], 26, 1);
      convert(rng[11:0], 26, 2);
      drainOn = 1'b1;
      // One pop must free a slot, else the next frame would be refused
      while (expQ.size() > 3) @(negedge clock);
      // Short cycles after 8 and 3 bits must push nothing
      convert(rng[11:0], 10, 0);
      convert(rng[11:0], 5, 0);
      for (int k = 0; k < 5; k++) convert(rng[11:0], 26, 1);
      for (int k = 0; k < 500 && expQ.size() != 0; k++) @(negedge clock);
      repeat (3) @(negedge clock);
      chk({11'h0, resultValid}, 12'h000);
      chk(12'(expQ.size()), 12'h000);
      report_and_stop();
   end
endmodule // tb

`default_nettype wire
